// File: hw/csia_pkg.sv
// register map, field layout, reset values and types of the upper sfr bank
// assumes a 20 mhz core clock and word-aligned wishbone byte addresses
package csia_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADR_W = 14;
  localparam int IDX_W = 12;
  localparam int PTR_W = 12;
  localparam int NPTR = 3;
  localparam int PC_W = 21;
  localparam int TBL_W = 22;
  // ------------------------------------------------------------
  // register indexes (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [11:0] PTR2_LOW_IDX = 12'hfd9;
  localparam logic [11:0] PTR2_HIGH_IDX = 12'hfda;
  localparam logic [11:0] PTR2_OFFSET_PORT_IDX = 12'hfdb;
  localparam logic [11:0] PTR2_PREINC_PORT_IDX = 12'hfdc;
  localparam logic [11:0] PTR2_POSTDEC_PORT_IDX = 12'hfdd;
  localparam logic [11:0] PTR2_POSTINC_PORT_IDX = 12'hfde;
  localparam logic [11:0] PTR2_PLAIN_PORT_IDX = 12'hfdf;
  localparam logic [11:0] BANK_SELECT_IDX = 12'hfe0;
  localparam logic [11:0] PTR1_LOW_IDX = 12'hfe1;
  localparam logic [11:0] PTR1_HIGH_IDX = 12'hfe2;
  localparam logic [11:0] PTR1_OFFSET_PORT_IDX = 12'hfe3;
  localparam logic [11:0] PTR1_PREINC_PORT_IDX = 12'hfe4;
  localparam logic [11:0] PTR1_POSTDEC_PORT_IDX = 12'hfe5;
  localparam logic [11:0] PTR1_POSTINC_PORT_IDX = 12'hfe6;
  localparam logic [11:0] PTR1_PLAIN_PORT_IDX = 12'hfe7;
  localparam logic [11:0] WORKING_ACCUMULATOR_IDX = 12'hfe8;
  localparam logic [11:0] PTR0_LOW_IDX = 12'hfe9;
  localparam logic [11:0] PTR0_HIGH_IDX = 12'hfea;
  localparam logic [11:0] PTR0_OFFSET_PORT_IDX = 12'hfeb;
  localparam logic [11:0] PTR0_PREINC_PORT_IDX = 12'hfec;
  localparam logic [11:0] PTR0_POSTDEC_PORT_IDX = 12'hfed;
  localparam logic [11:0] PTR0_POSTINC_PORT_IDX = 12'hfee;
  localparam logic [11:0] PTR0_PLAIN_PORT_IDX = 12'hfef;
  localparam logic [11:0] IRQ_CONTROL_THREE_IDX = 12'hff0;
  localparam logic [11:0] IRQ_CONTROL_TWO_IDX = 12'hff1;
  localparam logic [11:0] IRQ_CONTROL_MAIN_IDX = 12'hff2;
  localparam logic [11:0] MULTIPLY_RESULT_LOW_IDX = 12'hff3;
  localparam logic [11:0] MULTIPLY_RESULT_HIGH_IDX = 12'hff4;
  localparam logic [11:0] PROGRAM_TABLE_LATCH_IDX = 12'hff5;
  localparam logic [11:0] PROGRAM_TABLE_PTR_LOW_IDX = 12'hff6;
  localparam logic [11:0] PROGRAM_TABLE_PTR_HIGH_IDX = 12'hff7;
  localparam logic [11:0] PROGRAM_TABLE_PTR_UPPER_IDX = 12'hff8;
  localparam logic [11:0] PROG_COUNTER_LOW_IDX = 12'hff9;
  localparam logic [11:0] PROG_COUNTER_HIGH_LATCH_IDX = 12'hffa;
  localparam logic [11:0] PROG_COUNTER_UPPER_LATCH_IDX = 12'hffb;
  localparam logic [11:0] RETURN_STACK_POINTER_IDX = 12'hffc;
  localparam logic [11:0] STACK_TOP_LOW_IDX = 12'hffd;
  localparam logic [11:0] STACK_TOP_HIGH_IDX = 12'hffe;
  localparam logic [11:0] STACK_TOP_UPPER_IDX = 12'hfff;
  // per-pointer tables, pointer 0 first
  localparam logic [11:0] PTR_LOW [NPTR] = '{PTR0_LOW_IDX, PTR1_LOW_IDX, PTR2_LOW_IDX};
  localparam logic [11:0] PTR_HIGH [NPTR] = '{PTR0_HIGH_IDX, PTR1_HIGH_IDX, PTR2_HIGH_IDX};
  localparam logic [11:0] PTR_OFS [NPTR] =
    '{PTR0_OFFSET_PORT_IDX, PTR1_OFFSET_PORT_IDX, PTR2_OFFSET_PORT_IDX};
  localparam logic [11:0] PTR_PRE [NPTR] =
    '{PTR0_PREINC_PORT_IDX, PTR1_PREINC_PORT_IDX, PTR2_PREINC_PORT_IDX};
  localparam logic [11:0] PTR_PDEC [NPTR] =
    '{PTR0_POSTDEC_PORT_IDX, PTR1_POSTDEC_PORT_IDX, PTR2_POSTDEC_PORT_IDX};
  localparam logic [11:0] PTR_PINC [NPTR] =
    '{PTR0_POSTINC_PORT_IDX, PTR1_POSTINC_PORT_IDX, PTR2_POSTINC_PORT_IDX};
  localparam logic [11:0] PTR_PLAIN [NPTR] =
    '{PTR0_PLAIN_PORT_IDX, PTR1_PLAIN_PORT_IDX, PTR2_PLAIN_PORT_IDX};
  // ------------------------------------------------------------
  // field widths and reset values
  // ------------------------------------------------------------
  localparam int BSR_W = 4;
  localparam int PTRH_W = 4;
  localparam int TBLU_W = 6;
  localparam int UPPER_W = 5;
  localparam int STK_FULL_BIT = 7;
  localparam int STK_UNDER_BIT = 6;
  localparam int STK_PTR_W = 5;
  localparam logic [7:0] IRQ_THREE_RST = 8'hc0;
  localparam logic [7:0] IRQ_TWO_RST = 8'hff;
  localparam logic [7:0] IRQ_MAIN_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_STEP = 12'h001;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CSIA_M_PLAIN = 3'h0,
    CSIA_M_POSTINC = 3'h1,
    CSIA_M_POSTDEC = 3'h2,
    CSIA_M_PREINC = 3'h3,
    CSIA_M_OFFSET = 3'h4
  } csia_mode_e;
  typedef enum logic [1:0] {
    CSIA_S_IDLE = 2'b00,
    CSIA_S_MEM = 2'b01,
    CSIA_S_RESP = 2'b11
  } csia_state_e;
  typedef struct packed {
    logic hit;
    logic [1:0] ptr;
    csia_mode_e mode;
  } csia_port_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [PTR_W-1:0] addr;
    logic [7:0] wdata;
  } csia_dm_req_s;
  typedef struct packed {
    logic [PC_W-1:0] pc_now;
    logic [PC_W-1:0] stack_top_address;
    logic prod_load;
    logic [15:0] prod_value;
    logic table_load;
    logic [7:0] table_value;
  } csia_core_in_s;
  typedef struct packed {
    logic [7:0] working_accumulator;
    logic [BSR_W-1:0] bank;
    logic [7:0] irq_main;
    logic [7:0] irq_two;
    logic [7:0] irq_three;
    logic [TBL_W-1:0] table_ptr;
    logic [7:0] stack_ptr;
    logic pc_load;
    logic [PC_W-1:0] pc_load_addr;
    logic tos_write;
    logic [1:0] tos_byte;
    logic [7:0] tos_data;
  } csia_core_out_s;
endpackage

// File: hw/csia_regs.sv
// upper sfr bank: indirect pointers with their virtual ports, bank select,
// working register, product, interrupt control, table pointer, pc latches
// and stack top, reached as a classic wishbone slave
// assumes the core datapath and the data memory port run on ref_clk
//
// What this block does
// - virtual pointer ports read or write data memory at an address formed from their pointer; no storage.
// - pre-increment port bumps the pointer first, then uses the new value.
// - post-decrement port uses the current pointer, then decrements it.
// - upper pc bits come from a holding latch when the pc is loaded.
// - stack top bits 15..8 readable as a byte beside low and upper bytes.
// - offset port addresses pointer plus working register; pointer unchanged.
// - post-increment bumps, decrement ports decrement, plain port leaves pointer alone.
`timescale 1ns/10ps
module csia_regs
  import csia_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [csia_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output csia_pkg::csia_dm_req_s dm_req,
  input wire logic dm_ack,
  input wire logic [7:0] dm_rdata,
  input csia_pkg::csia_core_in_s core_in,
  output csia_pkg::csia_core_out_s core_out
);
  import csia_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  csia_state_e state;
  csia_state_e next_state;
  logic [PTR_W-1:0] ptr [NPTR];
  logic [1:0] acc_ptr;
  csia_mode_e acc_mode;
  logic [7:0] working_accumulator;
  logic [BSR_W-1:0] bank;
  logic [7:0] irq_main;
  logic [7:0] irq_two;
  logic [7:0] irq_three;
  logic [7:0] prod_low;
  logic [7:0] prod_high;
  logic [7:0] table_latch;
  logic [TBL_W-1:0] table_ptr;
  logic [7:0] pc_high_latch;
  logic [UPPER_W-1:0] upper_counter_holding_latch;
  logic [7:0] stack_ptr;
  logic pc_load;
  logic [PC_W-1:0] pc_load_addr;
  logic tos_write;
  logic [1:0] tos_byte;
  logic [7:0] tos_data;
  logic [7:0] rd_byte;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic req;
  logic reg_wr;
  logic reg_rd;
  csia_port_s port;
  logic [7:0] reg_rdata;
  logic [PTR_W-1:0] cur_ptr;
  logic [PTR_W-1:0] launch_addr;
  logic [PTR_W-1:0] ptr_after;
  logic mem_done;

  assign idx = wb_adr_i[ADR_W-1:2];
  assign req = wb_cyc_i && wb_stb_i && (state == CSIA_S_IDLE);
  assign reg_wr = req && wb_we_i && wb_sel_i[0] && !port.hit;
  assign reg_rd = req && !wb_we_i && !port.hit;
  assign mem_done = (state == CSIA_S_MEM) && dm_ack;

  // virtual ports map to a pointer and an addressing mode
  function automatic csia_port_s port_decode(input logic [IDX_W-1:0] a);
    csia_port_s d;
    d = '0;
    for (int p = 0; p < NPTR; p++)
    begin
      if (a == PTR_PLAIN[p] || a == PTR_PINC[p] || a == PTR_PDEC[p] ||
          a == PTR_PRE[p] || a == PTR_OFS[p])
      begin
        d.hit = 1'b1;
        d.ptr = p[1:0];
        if (a == PTR_PINC[p])
          d.mode = CSIA_M_POSTINC;
        else if (a == PTR_PDEC[p])
          d.mode = CSIA_M_POSTDEC;
        else if (a == PTR_PRE[p])
          d.mode = CSIA_M_PREINC;
        else if (a == PTR_OFS[p])
          d.mode = CSIA_M_OFFSET;
        else
          d.mode = CSIA_M_PLAIN;
      end
    end
    return d;
  endfunction

  assign port = port_decode(idx);
  assign cur_ptr = ptr[port.ptr];

  // address used for the data memory cycle
  always_comb
  begin
    case (port.mode)
      CSIA_M_PREINC: launch_addr = cur_ptr + PTR_STEP;
      CSIA_M_OFFSET: launch_addr = cur_ptr + {4'h0, working_accumulator};
      default: launch_addr = cur_ptr;
    endcase
  end

  // pointer value once the memory cycle completes
  always_comb
  begin
    case (acc_mode)
      CSIA_M_POSTINC: ptr_after = ptr[acc_ptr] + PTR_STEP;
      CSIA_M_PREINC: ptr_after = ptr[acc_ptr] + PTR_STEP;
      CSIA_M_POSTDEC: ptr_after = ptr[acc_ptr] - PTR_STEP;
      default: ptr_after = ptr[acc_ptr];
    endcase
  end

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      CSIA_S_IDLE:
        if (req)
          next_state = port.hit ? CSIA_S_MEM : CSIA_S_RESP;
      CSIA_S_MEM:
        if (dm_ack)
          next_state = CSIA_S_RESP;
      CSIA_S_RESP:
        next_state = CSIA_S_IDLE;
      default:
        next_state = CSIA_S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= CSIA_S_IDLE;
    else
      state <= next_state;
  end

  assign wb_ack_o = (state == CSIA_S_RESP);
  assign wb_dat_o = {24'h000000, rd_byte};

  // data memory request held until acknowledged; the port keeps no data
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dm_req <= '0;
      acc_ptr <= 2'h0;
      acc_mode <= CSIA_M_PLAIN;
    end
    else if (req && port.hit)
    begin
      dm_req.req <= 1'b1;
      dm_req.we <= wb_we_i && wb_sel_i[0];
      dm_req.addr <= launch_addr;
      dm_req.wdata <= wb_dat_i[7:0];
      acc_ptr <= port.ptr;
      acc_mode <= port.mode;
    end
    else if (mem_done)
      dm_req.req <= 1'b0;
  end

  // read data: register value, or memory byte for a port
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_byte <= BYTE_RST;
    else if (reg_rd)
      rd_byte <= reg_rdata;
    else if (req)
      rd_byte <= BYTE_RST;
    else if (mem_done && !dm_req.we)
      rd_byte <= dm_rdata;
  end

  // ------------------------------------------------------------
  // indirect pointers
  // ------------------------------------------------------------
  for (genvar p = 0; p < NPTR; p++)
  begin : g_ptr
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
      if (!rst_b)
        ptr[p] <= '0;
      else if (reg_wr && idx == PTR_LOW[p])
        ptr[p][7:0] <= wb_dat_i[7:0];
      else if (reg_wr && idx == PTR_HIGH[p])
        ptr[p][PTR_W-1:8] <= wb_dat_i[PTRH_W-1:0];
      else if (mem_done && acc_ptr == 2'(p))
        ptr[p] <= ptr_after;
    end
  end

  // ------------------------------------------------------------
  // bank select and working register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bank <= '0;
      working_accumulator <= BYTE_RST;
    end
    else if (reg_wr && idx == BANK_SELECT_IDX)
      bank <= wb_dat_i[BSR_W-1:0];
    else if (reg_wr && idx == WORKING_ACCUMULATOR_IDX)
      working_accumulator <= wb_dat_i[7:0];
  end

  // ------------------------------------------------------------
  // interrupt control bytes
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_three <= IRQ_THREE_RST;
      irq_two <= IRQ_TWO_RST;
      irq_main <= IRQ_MAIN_RST;
    end
    else if (reg_wr && idx == IRQ_CONTROL_THREE_IDX)
      irq_three <= wb_dat_i[7:0];
    else if (reg_wr && idx == IRQ_CONTROL_TWO_IDX)
      irq_two <= wb_dat_i[7:0];
    else if (reg_wr && idx == IRQ_CONTROL_MAIN_IDX)
      irq_main <= wb_dat_i[7:0];
  end

  // ------------------------------------------------------------
  // product and table registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prod_low <= BYTE_RST;
      prod_high <= BYTE_RST;
    end
    else if (core_in.prod_load)
      {prod_high, prod_low} <= core_in.prod_value;
    else if (reg_wr && idx == MULTIPLY_RESULT_LOW_IDX)
      prod_low <= wb_dat_i[7:0];
    else if (reg_wr && idx == MULTIPLY_RESULT_HIGH_IDX)
      prod_high <= wb_dat_i[7:0];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      table_latch <= BYTE_RST;
      table_ptr <= '0;
    end
    else if (core_in.table_load)
      table_latch <= core_in.table_value;
    else if (reg_wr && idx == PROGRAM_TABLE_LATCH_IDX)
      table_latch <= wb_dat_i[7:0];
    else if (reg_wr && idx == PROGRAM_TABLE_PTR_LOW_IDX)
      table_ptr[7:0] <= wb_dat_i[7:0];
    else if (reg_wr && idx == PROGRAM_TABLE_PTR_HIGH_IDX)
      table_ptr[15:8] <= wb_dat_i[7:0];
    else if (reg_wr && idx == PROGRAM_TABLE_PTR_UPPER_IDX)
      table_ptr[TBL_W-1:16] <= wb_dat_i[TBLU_W-1:0];
  end

  // ------------------------------------------------------------
  // program counter latches
  // ------------------------------------------------------------
  // reading the low byte snapshots the upper pc bits into the latches
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_high_latch <= BYTE_RST;
      upper_counter_holding_latch <= '0;
    end
    else if (reg_rd && idx == PROG_COUNTER_LOW_IDX)
    begin
      pc_high_latch <= core_in.pc_now[15:8];
      upper_counter_holding_latch <= core_in.pc_now[PC_W-1:16];
    end
    else if (reg_wr && idx == PROG_COUNTER_HIGH_LATCH_IDX)
      pc_high_latch <= wb_dat_i[7:0];
    else if (reg_wr && idx == PROG_COUNTER_UPPER_LATCH_IDX)
      upper_counter_holding_latch <= wb_dat_i[UPPER_W-1:0];
  end

  // writing the low byte loads the whole pc, upper bits from the latches
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_load <= 1'b0;
      pc_load_addr <= '0;
    end
    else
    begin
      pc_load <= reg_wr && idx == PROG_COUNTER_LOW_IDX;
      if (reg_wr && idx == PROG_COUNTER_LOW_IDX)
        pc_load_addr <= {upper_counter_holding_latch, pc_high_latch, wb_dat_i[7:0]};
    end
  end

  // ------------------------------------------------------------
  // return stack pointer and top of stack
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      stack_ptr <= BYTE_RST;
    else if (reg_wr && idx == RETURN_STACK_POINTER_IDX)
    begin
      stack_ptr[STK_FULL_BIT] <= wb_dat_i[STK_FULL_BIT];
      stack_ptr[STK_UNDER_BIT] <= wb_dat_i[STK_UNDER_BIT];
      stack_ptr[STK_PTR_W-1:0] <= wb_dat_i[STK_PTR_W-1:0];
    end
  end

  // top-of-stack writes go to the core's stack as a byte pulse
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tos_write <= 1'b0;
      tos_byte <= 2'h0;
      tos_data <= BYTE_RST;
    end
    else
    begin
      tos_write <= reg_wr && (idx == STACK_TOP_LOW_IDX || idx == STACK_TOP_HIGH_IDX ||
                              idx == STACK_TOP_UPPER_IDX);
      if (reg_wr)
      begin
        tos_byte <= idx[1:0] - 2'h1;
        tos_data <= (idx == STACK_TOP_UPPER_IDX) ?
                    {3'h0, wb_dat_i[UPPER_W-1:0]} : wb_dat_i[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  always_comb
  begin
    reg_rdata = 8'h00;
    for (int p = 0; p < NPTR; p++)
    begin
      if (idx == PTR_LOW[p])
        reg_rdata = ptr[p][7:0];
      if (idx == PTR_HIGH[p])
        reg_rdata = {4'h0, ptr[p][PTR_W-1:8]};
    end
    case (idx)
      BANK_SELECT_IDX: reg_rdata = {4'h0, bank};
      WORKING_ACCUMULATOR_IDX: reg_rdata = working_accumulator;
      IRQ_CONTROL_THREE_IDX: reg_rdata = irq_three;
      IRQ_CONTROL_TWO_IDX: reg_rdata = irq_two;
      IRQ_CONTROL_MAIN_IDX: reg_rdata = irq_main;
      MULTIPLY_RESULT_LOW_IDX: reg_rdata = prod_low;
      MULTIPLY_RESULT_HIGH_IDX: reg_rdata = prod_high;
      PROGRAM_TABLE_LATCH_IDX: reg_rdata = table_latch;
      PROGRAM_TABLE_PTR_LOW_IDX: reg_rdata = table_ptr[7:0];
      PROGRAM_TABLE_PTR_HIGH_IDX: reg_rdata = table_ptr[15:8];
      PROGRAM_TABLE_PTR_UPPER_IDX: reg_rdata = {2'h0, table_ptr[TBL_W-1:16]};
      PROG_COUNTER_LOW_IDX: reg_rdata = core_in.pc_now[7:0];
      PROG_COUNTER_HIGH_LATCH_IDX: reg_rdata = pc_high_latch;
      PROG_COUNTER_UPPER_LATCH_IDX: reg_rdata = {3'h0, upper_counter_holding_latch};
      RETURN_STACK_POINTER_IDX: reg_rdata = stack_ptr;
      STACK_TOP_LOW_IDX: reg_rdata = core_in.stack_top_address[7:0];
      STACK_TOP_HIGH_IDX: reg_rdata = core_in.stack_top_address[15:8];
      STACK_TOP_UPPER_IDX: reg_rdata = {3'h0, core_in.stack_top_address[PC_W-1:16]};
      default: ;
    endcase
  end

  // ------------------------------------------------------------
  // core-side outputs
  // ------------------------------------------------------------
  always_comb
  begin
    core_out.working_accumulator = working_accumulator;
    core_out.bank = bank;
    core_out.irq_main = irq_main;
    core_out.irq_two = irq_two;
    core_out.irq_three = irq_three;
    core_out.table_ptr = table_ptr;
    core_out.stack_ptr = stack_ptr;
    core_out.pc_load = pc_load;
    core_out.pc_load_addr = pc_load_addr;
    core_out.tos_write = tos_write;
    core_out.tos_byte = tos_byte;
    core_out.tos_data = tos_data;
  end

endmodule

// File: test/csia_dmem.sv
// behavioural data memory on the far side of the block's data memory port
// assumes one access at a time; lat sets the answer delay in cycles
`timescale 1ns/10ps
module csia_dmem
  import csia_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input csia_pkg::csia_dm_req_s dm_req,
  input wire logic [3:0] lat,
  output logic dm_ack,
  output logic [7:0] dm_rdata
);
  logic [7:0] mem [4096];
  logic [3:0] cnt;
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  // idle data toggles so a stale byte never passes for an answer
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 4'h0;
      dm_ack <= 1'b0;
      dm_rdata <= 8'h00;
    end
    else if (dm_req.req && !dm_ack && cnt >= lat)
    begin
      cnt <= 4'h0;
      dm_ack <= 1'b1;
      dm_rdata <= dm_req.we ? ~dm_rdata : mem[dm_req.addr];
      if (dm_req.we)
        mem[dm_req.addr] <= dm_req.wdata;
    end
    else
    begin
      cnt <= dm_req.req ? cnt + 4'h1 : 4'h0;
      dm_ack <= 1'b0;
      dm_rdata <= ~dm_rdata;
    end
  end
endmodule

// File: test/csia_regs_asserts.sv
// port-level checker for csia_regs, bound below
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
module csia_regs_asserts
  import csia_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [csia_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input csia_pkg::csia_dm_req_s dm_req,
  input wire logic dm_ack,
  input wire logic [7:0] dm_rdata,
  input csia_pkg::csia_core_out_s core_out
);
  logic [11:0] idx;
  logic port_hit;
  assign idx = wb_adr_i[13:2];
  assign port_hit = (idx >= 12'hfdb && idx <= 12'hfdf) || (idx >= 12'hfe3 && idx <= 12'hfe7)
    || (idx >= 12'hfeb && idx <= 12'hfef);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence take;
    $rose(wb_stb_i) && wb_cyc_i;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  reg_latency_a: assert property (take ##0 !port_hit |=> wb_ack_o && !dm_req.req)
    else $error("plain register not answered in one cycle");
  port_start_a: assert property (take ##0 port_hit |=> dm_req.req && !wb_ack_o)
    else $error("pointer port did not reach data memory");
  dm_hold_a: assert property (dm_req.req && !dm_ack |=> $stable(dm_req))
    else $error("memory request changed before answer");
  dm_drop_a: assert property (dm_req.req && dm_ack |=> !dm_req.req)
    else $error("memory request not released");
  port_ack_a: assert property (dm_req.req && dm_ack |=> wb_ack_o)
    else $error("bus not answered after memory answer");
  port_rdata_a: assert property (dm_req.req && dm_ack && !dm_req.we
    |=> wb_dat_o[7:0] == $past(dm_rdata))
    else $error("port read data differs from memory");
  pc_load_a: assert property (take ##0 wb_we_i && wb_sel_i[0] && idx == 12'hff9
    |=> core_out.pc_load && core_out.pc_load_addr[7:0] == $past(wb_dat_i[7:0]))
    else $error("counter load missing after low byte write");
  // ------------------------------------------------------------
  // covers
  // ------------------------------------------------------------
  port_done_c: cover property (dm_req.req && dm_ack ##1 wb_ack_o);
  pc_load_c: cover property (core_out.pc_load);
  plain_c: cover property (take ##0 !port_hit ##1 wb_ack_o);
endmodule
bind csia_regs csia_regs_asserts csia_regs_asserts_inst (.ref_clk, .rst_b, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dm_req,
  .dm_ack, .dm_rdata, .core_out);

// File: test/csia_regs_bench.sv
// self-checking bench for csia_regs with a behavioural data memory
// assumes the memory presets each byte to its address xor 5a
`timescale 1ns/10ps
module csia_regs_bench;
  import csia_pkg::*;
  typedef struct {logic we; logic [11:0] idx; logic [7:0] wd; logic [7:0] ex;} csia_row_s;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  csia_dm_req_s dm_req;
  logic dm_ack;
  logic [7:0] dm_rdata;
  csia_core_in_s core_in = '{pc_now: 21'h1abcde, stack_top_address: 21'h0f1234, default: '0};
  csia_core_out_s core_out;
  logic [3:0] lat = 4'h0;
  logic [7:0] rd;
  logic [11:0] dm_addr;
  logic [PC_W-1:0] pc_cap;
  int error_cnt = 0;
  int comparisons = 0;
  csia_row_s rows [11] = '{
    '{1'b1, 12'hfe0, 8'hff, 8'h0f},
    '{1'b1, 12'hfe2, 8'hff, 8'h0f},
    '{1'b1, 12'hff8, 8'hff, 8'h3f},
    '{1'b1, 12'hffb, 8'hff, 8'h1f},
    '{1'b1, 12'hffc, 8'hff, 8'hdf},
    '{1'b1, 12'hfe8, 8'ha5, 8'ha5},
    '{1'b1, 12'hff2, 8'h3c, 8'h3c},
    '{1'b1, 12'h100, 8'h55, 8'h00},
    '{1'b0, 12'hffd, 8'h00, 8'h34},
    '{1'b0, 12'hffe, 8'h00, 8'h12},
    '{1'b0, 12'hfff, 8'h00, 8'h0f}};
  csia_regs csia_regs_inst (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dm_req, .dm_ack, .dm_rdata, .core_in,
    .core_out);
  csia_dmem csia_dmem_inst (.ref_clk, .rst_b, .dm_req, .lat, .dm_ack, .dm_rdata);
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (core_out.pc_load === 1'b1)
      pc_cap <= core_out.pc_load_addr;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, ex, got);
    end
  endtask
  task automatic xfer(input logic we, input logic [11:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    dm_addr = 'x;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, wd};
    do
    begin
      @(posedge ref_clk);
      n++;
      if (dm_ack === 1'b1 && dm_req.req === 1'b1)
        dm_addr = dm_req.addr;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    chk("bus ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] idx, input logic [7:0] ex);
    xfer(1'b0, idx, 8'h00);
    chk("register read", {24'h0, ex}, {24'h0, rd});
  endtask
  task automatic setp(input logic [11:0] lo, input logic [11:0] v);
    xfer(1'b1, lo, v[7:0]);
    xfer(1'b1, lo + 12'h001, {4'h0, v[11:8]});
  endtask
  // port read: memory address, data, then the pointer left behind
  task automatic port(input logic [11:0] idx, lo, ea, ep);
    xfer(1'b0, idx, 8'h00);
    chk("port address", {20'h0, ea}, {20'h0, dm_addr});
    chk("port data", {24'h0, ea[7:0] ^ 8'h5a}, {24'h0, rd});
    rdchk(lo, ep[7:0]);
    rdchk(lo + 12'h001, {4'h0, ep[11:8]});
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].we)
        xfer(1'b1, rows[i].idx, rows[i].wd);
      rdchk(rows[i].idx, rows[i].ex);
    end
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdchk(12'hff0, IRQ_THREE_RST);
    rdchk(12'hff1, IRQ_TWO_RST);
    rdchk(12'hfe0, 8'h00);
    rdchk(12'hfe8, 8'h00);
    core_in.prod_load <= 1'b1;
    core_in.prod_value <= 16'hbeef;
    core_in.table_load <= 1'b1;
    core_in.table_value <= 8'h6c;
    @(posedge ref_clk);
    core_in.prod_load <= 1'b0;
    core_in.table_load <= 1'b0;
    rdchk(12'hff3, 8'hef);
    rdchk(12'hff4, 8'hbe);
    rdchk(12'hff5, 8'h6c);
    xfer(1'b1, 12'hffb, 8'h15);
    xfer(1'b1, 12'hffa, 8'h2c);
    xfer(1'b1, 12'hff9, 8'h3d);
    xfer(1'b0, 12'hff9, 8'h00);
    chk("counter load", {11'h0, 21'h152c3d}, {11'h0, pc_cap});
    rdchk(12'hffa, 8'hbc);
    rdchk(12'hffb, 8'h1a);
    xfer(1'b1, 12'hfe8, 8'h05);
    setp(12'hfe9, 12'h0ff);
    port(12'hfee, 12'hfe9, 12'h0ff, 12'h100);
    port(12'hfed, 12'hfe9, 12'h100, 12'h0ff);
    port(12'hfec, 12'hfe9, 12'h100, 12'h100);
    port(12'hfeb, 12'hfe9, 12'h105, 12'h100);
    port(12'hfef, 12'hfe9, 12'h100, 12'h100);
    lat <= 4'h3;
    setp(12'hfe1, 12'hfff);
    port(12'hfe6, 12'hfe1, 12'hfff, 12'h000);
    port(12'hfe3, 12'hfe1, 12'h005, 12'h000);
    setp(12'hfd9, 12'h000);
    port(12'hfdd, 12'hfd9, 12'h000, 12'hfff);
    port(12'hfdc, 12'hfd9, 12'h000, 12'h000);
    xfer(1'b1, 12'hfe7, 8'h77);
    chk("plain write address", 32'h0, {20'h0, dm_addr});
    rdchk(12'hfdf, 8'h77);
    close_out();
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("BAD watchdog expected end seen hang");
    close_out();
  end
endmodule
